// file: hw/mmp_top.sv
// Summary of operation
// - Thirty-two byte registers, each read or written in one clock cycle.
// - Register pairs 26-31 form pointers X, Y and Z into data space; only Z also addresses program space.
// - Program and data addresses decode in separate spaces independently.
// - All I/O registers sit below data address 0x1000.
// - Direct I/O instructions reach data addresses 0x00 to 0x3F only.
// - Extended I/O 0x0040-0x0FFF is reached only by data loads and stores.
// - Data addresses 0x1000-0x1FFF form the nonvolatile byte memory window.
// - SRAM starts at data address 0x2000 and runs upward.
// - Instructions are fetched from program flash only.
// - Flash holds 16-bit words; instructions take one or two words.
// - Self-write only programs when its program counter is in the boot section.
// - From the boot section a self-write may target any flash word outside a write-locked section.
// - Application and boot sections have separate write and read locks.
// - Table section tops the application section, boot-sized, own locks.
// - Flash is read and written by the external programmer and by software.
// - Section sizes are fixed constants, not run-time settings.
`timescale 1ns/1ps
`default_nettype none
module mmp_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] rf_rd_a_addr,
    input wire logic [4:0] rf_rd_b_addr,
    output logic [7:0] rf_rd_a_data,
    output logic [7:0] rf_rd_b_data,
    input wire logic rf_we,
    input wire logic [4:0] rf_wr_addr,
    input wire logic [7:0] rf_wr_data,
    input wire logic rf_ptr_we,
    input wire logic [1:0] rf_ptr_sel,
    input wire logic [15:0] rf_ptr_wdata,
    output logic [15:0] ptr_x,
    output logic [15:0] ptr_y,
    output logic [15:0] ptr_z,
    input wire logic d_req,
    input wire logic d_we,
    input wire logic d_io_instr,
    input wire logic [1:0] d_ptr_sel,
    input wire logic [15:0] d_addr,
    output logic d_valid,
    output logic d_we_out,
    output logic [1:0] d_region,
    output logic [15:0] d_eff_addr,
    output logic [15:0] d_offset,
    input wire logic fetch_req,
    input wire logic [14:0] fetch_pc,
    output logic fetch_valid,
    output logic fetch_fault,
    output logic [15:0] fetch_word,
    input wire logic pm_rd_req,
    input wire logic [14:0] pm_rd_pc,
    output logic pm_rd_valid,
    output logic pm_rd_denied,
    output logic [15:0] pm_rd_word,
    input wire logic spm_req,
    input wire logic [14:0] spm_pc,
    input wire logic [14:0] spm_addr,
    input wire logic [15:0] spm_data,
    output logic spm_busy,
    output logic spm_done,
    output logic spm_refused,
    input wire logic [1:0] lock_app,
    input wire logic [1:0] lock_tbl,
    input wire logic [1:0] lock_boot,
    input wire logic ext_req,
    input wire logic ext_we,
    input wire logic [14:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    output logic ext_valid,
    output logic ext_denied,
    output logic [15:0] ext_rdata
);
    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    mmp_regfile u_regfile (
        .clk(clk),
        .arst_n(arst_n),
        .rd_a_addr(rf_rd_a_addr),
        .rd_b_addr(rf_rd_b_addr),
        .rd_a_data(rf_rd_a_data),
        .rd_b_data(rf_rd_b_data),
        .we(rf_we),
        .wr_addr(rf_wr_addr),
        .wr_data(rf_wr_data),
        .ptr_we(rf_ptr_we),
        .ptr_sel(rf_ptr_sel),
        .ptr_wdata(rf_ptr_wdata),
        .ptr_x(ptr_x),
        .ptr_y(ptr_y),
        .ptr_z(ptr_z)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data space decode. A direct I/O instruction carries only six address
    // bits, so it can never land above the low 64 locations.
    logic [15:0] next_eff;
    always_comb begin
        if (d_io_instr) begin
            next_eff = {10'h000, d_addr[mmp_pkg::IO_DIRECT_W-1:0]};
        end else begin
            case (d_ptr_sel)
                mmp_pkg::PTR_SEL_X: next_eff = ptr_x;
                mmp_pkg::PTR_SEL_Y: next_eff = ptr_y;
                mmp_pkg::PTR_SEL_Z: next_eff = ptr_z;
                default: next_eff = d_addr;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_valid <= 1'b0;
            d_we_out <= 1'b0;
            d_region <= 2'h0;
            d_eff_addr <= 16'h0000;
            d_offset <= 16'h0000;
        end else begin
            d_valid <= d_req;
            d_we_out <= d_req && d_we;
            if (d_req) begin
                d_region <= mmp_pkg::mmp_region_of(next_eff);
                d_eff_addr <= next_eff;
                case (mmp_pkg::mmp_region_of(next_eff))
                    mmp_pkg::REGION_EEP: d_offset <= next_eff - mmp_pkg::EEP_FIRST;
                    mmp_pkg::REGION_SRAM: d_offset <= next_eff - mmp_pkg::SRAM_FIRST;
                    default: d_offset <= next_eff;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock lookup per section; each section owns its own pair of lock bits.
    function automatic logic [1:0] lock_of(input mmp_pkg::mmp_section_t sec,
                                           input logic [1:0] la,
                                           input logic [1:0] lt,
                                           input logic [1:0] lb);
        case (sec)
            mmp_pkg::SEC_APP: return la;
            mmp_pkg::SEC_APP_TBL: return lt;
            mmp_pkg::SEC_BOOT: return lb;
            default: return 2'h3;
        endcase
    endfunction

    mmp_pkg::mmp_section_t rd_sec;
    mmp_pkg::mmp_section_t ext_sec;
    logic pm_rd_block;
    logic ext_rd_block;
    logic ext_take;
    logic pm_take;
    logic [1:0] rd_lock;
    logic [1:0] ext_lock;
    assign rd_sec = mmp_pkg::mmp_section_of(ptr_z[15:1]);
    assign ext_sec = mmp_pkg::mmp_section_of(ext_addr);
    assign rd_lock = lock_of(rd_sec, lock_app, lock_tbl, lock_boot);
    assign ext_lock = lock_of(ext_sec, lock_app, lock_tbl, lock_boot);
    // A read-locked section is only readable by code running inside it.
    assign pm_rd_block = (rd_sec == mmp_pkg::SEC_NONE) ||
        (rd_lock[mmp_pkg::LOCK_RP_BIT] &&
         mmp_pkg::mmp_section_of(pm_rd_pc) != rd_sec);
    assign ext_rd_block = (ext_sec == mmp_pkg::SEC_NONE) || ext_lock[mmp_pkg::LOCK_RP_BIT];
    // The programmer owns the shared read port; a colliding software read is
    // dropped and must be asked again, trading latency for a single port.
    assign ext_take = ext_req && !ext_we;
    assign pm_take = pm_rd_req && !ext_take;

    ////////////////////////////////////////////////////////////////////////////
    // Self-write sequencer.
    mmp_pkg::mmp_sw_state_t sw_state;
    logic [14:0] sw_pc;
    logic [14:0] sw_addr;
    logic [15:0] sw_data;
    logic sw_allowed;
    logic ext_wr;
    logic spm_wr;
    logic mem_we;
    logic [14:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [1:0] sw_lock;

    assign sw_lock = lock_of(mmp_pkg::mmp_section_of(sw_addr), lock_app, lock_tbl, lock_boot);
    assign sw_allowed = (mmp_pkg::mmp_section_of(sw_pc) == mmp_pkg::SEC_BOOT) &&
        (mmp_pkg::mmp_section_of(sw_addr) != mmp_pkg::SEC_NONE) &&
        !sw_lock[mmp_pkg::LOCK_WP_BIT];
    assign ext_wr = ext_req && ext_we && (ext_addr <= mmp_pkg::FLASH_LAST);
    assign spm_wr = (sw_state == mmp_pkg::SW_WRITE) && !ext_wr;
    assign mem_we = ext_wr || spm_wr;
    assign mem_waddr = ext_wr ? ext_addr : sw_addr;
    assign mem_wdata = ext_wr ? ext_wdata : sw_data;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_pc <= 15'h0000;
            sw_addr <= 15'h0000;
            sw_data <= 16'h0000;
        end else if (sw_state == mmp_pkg::SW_IDLE && spm_req) begin
            sw_pc <= spm_pc;
            sw_addr <= spm_addr;
            sw_data <= spm_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_state <= mmp_pkg::SW_IDLE;
            spm_busy <= 1'b0;
            spm_done <= 1'b0;
            spm_refused <= 1'b0;
        end else begin
            spm_done <= 1'b0;
            spm_refused <= 1'b0;
            case (sw_state)
                mmp_pkg::SW_IDLE: begin
                    if (spm_req) begin
                        sw_state <= mmp_pkg::SW_CHECK;
                        spm_busy <= 1'b1;
                    end
                end
                mmp_pkg::SW_CHECK: begin
                    if (sw_allowed) begin
                        sw_state <= mmp_pkg::SW_WRITE;
                    end else begin
                        sw_state <= mmp_pkg::SW_IDLE;
                        spm_busy <= 1'b0;
                        spm_refused <= 1'b1;
                    end
                end
                mmp_pkg::SW_WRITE: begin
                    // The programmer's write goes first; the self-write waits.
                    if (!ext_wr) begin
                        sw_state <= mmp_pkg::SW_IDLE;
                        spm_busy <= 1'b0;
                        spm_done <= 1'b1;
                    end
                end
                default: begin
                    sw_state <= mmp_pkg::SW_IDLE;
                    spm_busy <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash array: port A fetches instructions, port B serves software program-memory reads and programmer reads.
    logic fetch_out_range;
    assign fetch_out_range = fetch_pc > mmp_pkg::FLASH_LAST;

    mmp_flash_mem u_flash (
        .clk(clk),
        .arst_n(arst_n),
        .a_addr(fetch_pc),
        .a_en(fetch_req),
        .a_zero(fetch_out_range),
        .a_data(fetch_word),
        .b_addr(ext_take ? ext_addr : ptr_z[15:1]),
        .b_en(ext_take || pm_take),
        .b_zero(ext_take ? ext_rd_block : pm_rd_block),
        .b_data(pm_rd_word),
        .we(mem_we),
        .w_addr(mem_waddr),
        .w_data(mem_wdata)
    );
    assign ext_rdata = pm_rd_word;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_valid <= 1'b0;
            fetch_fault <= 1'b0;
        end else begin
            fetch_valid <= fetch_req;
            fetch_fault <= fetch_req && fetch_out_range;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pm_rd_valid <= 1'b0;
            pm_rd_denied <= 1'b0;
            ext_valid <= 1'b0;
            ext_denied <= 1'b0;
        end else begin
            pm_rd_valid <= pm_take;
            pm_rd_denied <= pm_take && pm_rd_block;
            ext_valid <= ext_req;
            ext_denied <= ext_take ? ext_rd_block : (ext_req && !ext_wr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_spm_from_app;
        (sw_state == mmp_pkg::SW_IDLE && spm_req &&
         mmp_pkg::mmp_section_of(spm_pc) != mmp_pkg::SEC_BOOT) ##1
        (sw_state == mmp_pkg::SW_CHECK);
    endsequence

    spm_outside_boot_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_spm_from_app |=> spm_refused && !spm_busy)
        else $error("self-write from outside boot section was not refused");

    spm_gate_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mem_we && !ext_wr) |-> (mmp_pkg::mmp_section_of(sw_pc) == mmp_pkg::SEC_BOOT &&
            !sw_lock[mmp_pkg::LOCK_WP_BIT]))
        else $error("flash written by a self-write that should be refused");

    spm_boot_done_a: assert property (@(posedge clk) disable iff (!arst_n)
        (sw_state == mmp_pkg::SW_CHECK && sw_allowed && !ext_req) ##1 !ext_req
        |=> spm_done)
        else $error("allowed self-write did not complete");

    io_direct_dec_a: assert property (@(posedge clk) disable iff (!arst_n)
        (d_req && d_io_instr) |=> (d_region == mmp_pkg::REGION_IO &&
            d_eff_addr <= mmp_pkg::IO_DIRECT_LAST))
        else $error("direct I/O access decoded outside low I/O space");

    ext_io_dec_a: assert property (@(posedge clk) disable iff (!arst_n)
        (d_req && !d_io_instr && d_ptr_sel == 2'h0 && d_addr >= mmp_pkg::EXT_IO_FIRST &&
         d_addr <= mmp_pkg::EXT_IO_LAST) |=> d_region == mmp_pkg::REGION_EXT_IO)
        else $error("extended I/O load or store misdecoded");

    eep_window_a: assert property (@(posedge clk) disable iff (!arst_n)
        (d_valid && d_region == mmp_pkg::REGION_EEP) |->
        (d_eff_addr >= mmp_pkg::EEP_FIRST && d_eff_addr <= mmp_pkg::EEP_LAST &&
         d_offset == d_eff_addr - mmp_pkg::EEP_FIRST))
        else $error("nonvolatile window decode wrong");

    sram_base_a: assert property (@(posedge clk) disable iff (!arst_n)
        (d_valid && d_region == mmp_pkg::REGION_SRAM) |->
        (d_eff_addr >= mmp_pkg::SRAM_FIRST && d_offset == d_eff_addr - mmp_pkg::SRAM_FIRST))
        else $error("SRAM offset wrong");

    fetch_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
        fetch_req |=> (fetch_valid && fetch_fault == $past(fetch_out_range)))
        else $error("instruction fetch not answered next cycle");
endmodule
`default_nettype wire

// file: hw/mmp_pkg.sv
package mmp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // General register file.
    localparam int REG_COUNT = 32;
    localparam int REG_AW = 5;
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    localparam logic [1:0] PTR_SEL_X = 2'h1;
    localparam logic [1:0] PTR_SEL_Y = 2'h2;
    localparam logic [1:0] PTR_SEL_Z = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Data space map.
    localparam int ADDR_W = 16;
    localparam int IO_DIRECT_W = 6;
    localparam logic [15:0] IO_DIRECT_LAST = 16'h003f;
    localparam logic [15:0] EXT_IO_FIRST = 16'h0040;
    localparam logic [15:0] EXT_IO_LAST = 16'h0fff;
    localparam logic [15:0] EEP_FIRST = 16'h1000;
    localparam logic [15:0] EEP_LAST = 16'h1fff;
    localparam logic [15:0] SRAM_FIRST = 16'h2000;

    typedef enum logic [1:0] {
        REGION_IO = 2'h0,
        REGION_EXT_IO = 2'h1,
        REGION_EEP = 2'h2,
        REGION_SRAM = 2'h3
    } mmp_region_t;

    ////////////////////////////////////////////////////////////////////////////
    // Flash map, in 16-bit words; fixed for this variant.
    localparam int FLASH_W = 16;
    localparam int FLASH_AW = 15;
    localparam int FLASH_WORDS = 18432;
    localparam logic [14:0] APP_TBL_FIRST = 15'h3800;
    localparam logic [14:0] BOOT_FIRST = 15'h4000;
    localparam logic [14:0] FLASH_LAST = 15'h47ff;
    localparam int LOCK_W = 2;
    localparam int LOCK_WP_BIT = 0;
    localparam int LOCK_RP_BIT = 1;

    typedef enum logic [1:0] {
        SEC_APP = 2'h0,
        SEC_APP_TBL = 2'h1,
        SEC_BOOT = 2'h2,
        SEC_NONE = 2'h3
    } mmp_section_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_CHECK = 2'h1,
        SW_WRITE = 2'h3
    } mmp_sw_state_t;

    function automatic mmp_region_t mmp_region_of(input logic [15:0] addr);
        if (addr <= EXT_IO_LAST) begin
            return (addr <= IO_DIRECT_LAST) ? REGION_IO : REGION_EXT_IO;
        end else if (addr <= EEP_LAST) begin
            return REGION_EEP;
        end else begin
            return REGION_SRAM;
        end
    endfunction

    function automatic mmp_section_t mmp_section_of(input logic [14:0] waddr);
        if (waddr > FLASH_LAST) begin
            return SEC_NONE;
        end else if (waddr >= BOOT_FIRST) begin
            return SEC_BOOT;
        end else if (waddr >= APP_TBL_FIRST) begin
            return SEC_APP_TBL;
        end else begin
            return SEC_APP;
        end
    endfunction

endpackage

// file: hw/mmp_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module mmp_regfile (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] rd_a_addr,
    input wire logic [4:0] rd_b_addr,
    output logic [7:0] rd_a_data,
    output logic [7:0] rd_b_data,
    input wire logic we,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic ptr_we,
    input wire logic [1:0] ptr_sel,
    input wire logic [15:0] ptr_wdata,
    output logic [15:0] ptr_x,
    output logic [15:0] ptr_y,
    output logic [15:0] ptr_z
);
    logic [7:0] regs [mmp_pkg::REG_COUNT];

    function automatic logic ptr_hits(input logic [1:0] sel, input logic [4:0] idx);
        logic [4:0] lo;
        lo = (sel == mmp_pkg::PTR_SEL_X) ? mmp_pkg::PTR_X_LO :
             (sel == mmp_pkg::PTR_SEL_Y) ? mmp_pkg::PTR_Y_LO : mmp_pkg::PTR_Z_LO;
        return (sel != 2'h0) && (idx[4:1] == lo[4:1]);
    endfunction

    // A byte write beats a pointer write-back to the same byte, so an explicit
    // register move is never undone by an address post-increment.
    genvar gi;
    generate
        for (gi = 0; gi < mmp_pkg::REG_COUNT; gi++) begin : g_reg
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    regs[gi] <= 8'h00;
                end else if (we && wr_addr == 5'(gi)) begin
                    regs[gi] <= wr_data;
                end else if (ptr_we && ptr_hits(ptr_sel, 5'(gi))) begin
                    regs[gi] <= gi[0] ? ptr_wdata[15:8] : ptr_wdata[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_a_data <= 8'h00;
            rd_b_data <= 8'h00;
        end else begin
            rd_a_data <= regs[rd_a_addr];
            rd_b_data <= regs[rd_b_addr];
        end
    end

    assign ptr_x = {regs[mmp_pkg::PTR_X_LO + 5'h1], regs[mmp_pkg::PTR_X_LO]};
    assign ptr_y = {regs[mmp_pkg::PTR_Y_LO + 5'h1], regs[mmp_pkg::PTR_Y_LO]};
    assign ptr_z = {regs[mmp_pkg::PTR_Z_LO + 5'h1], regs[mmp_pkg::PTR_Z_LO]};

    ////////////////////////////////////////////////////////////////////////////
    sequence s_write_then_read;
        (we && !ptr_we) ##1 (rd_a_addr == $past(wr_addr));
    endsequence

    reg_write_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_write_then_read |=> rd_a_data == $past(wr_data, 2))
        else $error("register read does not return the byte written");

    pointer_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ptr_we && ptr_sel == mmp_pkg::PTR_SEL_Z && !we) |=> ptr_z == $past(ptr_wdata))
        else $error("pointer pair write-back lost");
endmodule
`default_nettype wire

// file: hw/mmp_flash_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mmp_flash_mem (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [14:0] a_addr,
    input wire logic a_en,
    input wire logic a_zero,
    output logic [15:0] a_data,
    input wire logic [14:0] b_addr,
    input wire logic b_en,
    input wire logic b_zero,
    output logic [15:0] b_data,
    input wire logic we,
    input wire logic [14:0] w_addr,
    input wire logic [15:0] w_data
);
    logic [15:0] mem [mmp_pkg::FLASH_WORDS];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[w_addr] <= w_data;
        end
    end

    // Zeroed reads keep locked or unmapped contents off the read registers.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_data <= 16'h0000;
        end else if (a_en) begin
            a_data <= a_zero ? 16'h0000 : mem[a_addr];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b_data <= 16'h0000;
        end else if (b_en) begin
            b_data <= b_zero ? 16'h0000 : mem[b_addr];
        end
    end
endmodule
`default_nettype wire

// file: tb/mmp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side of the self-write port; a request stands for exactly one taking edge.
module mmp_core_model (
    input wire logic clk,
    input wire logic spm_done,
    input wire logic spm_refused,
    output logic spm_req,
    output logic [14:0] spm_pc,
    output logic [14:0] spm_addr,
    output logic [15:0] spm_data
);
    initial begin
        spm_req = 1'b0;
        spm_pc = 15'h0;
        spm_addr = 15'h0;
        spm_data = 16'h0;
    end
    // Counts edges from the taking edge up to the closing pulse, bounded.
    task automatic self_write(input logic [14:0] pc, input logic [14:0] a,
        input logic [15:0] d, output int n, output logic refd);
        spm_req = 1'b1;
        spm_pc = pc;
        spm_addr = a;
        spm_data = d;
        @(posedge clk);
        #1;
        spm_req = 1'b0;
        // Released payload must not keep showing the value just written.
        spm_data = ~d;
        n = 1;
        while (!(spm_done || spm_refused) && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        refd = spm_refused;
    endtask
endmodule
`default_nettype wire

// file: tb/test_memory_map_and_flash_sections.sv
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_and_flash_sections;
    logic clk = 0, arst_n = 0, rf_we = 0, rf_ptr_we = 0, d_req = 0, d_we = 0, d_io = 0;
    logic fetch_req = 0, ext_req = 0, ext_we = 0, spm_req, d_valid, fetch_valid, fetch_fault;
    logic spm_busy, spm_done, spm_refused, ext_valid, ext_denied, d_we_out;
    logic [4:0] ra = 0, rb = 0, wa = 0;
    logic [7:0] wd = 0, rda, rdb;
    logic [1:0] psel = 0, dsel = 0, la = 0, lt = 0, lb = 0, d_region;
    logic [14:0] fpc = 0, ea = 0, spm_pc, spm_addr;
    logic [15:0] pwd = 0, da = 0, ewd = 0, spm_data, px, py, pz, eff, off, fw, erd, e;
    logic [15:0] fm [int];
    logic refd, pm_req = 0, pm_valid, pm_denied;
    logic [15:0] pm_word;
    int error_cnt = 0, compares = 0, seed = 23730, n;
    mmp_top i_dut (.clk(clk), .arst_n(arst_n), .rf_rd_a_addr(ra), .rf_rd_b_addr(rb),
        .rf_rd_a_data(rda), .rf_rd_b_data(rdb), .rf_we(rf_we), .rf_wr_addr(wa),
        .rf_wr_data(wd), .rf_ptr_we(rf_ptr_we), .rf_ptr_sel(psel), .rf_ptr_wdata(pwd),
        .ptr_x(px), .ptr_y(py), .ptr_z(pz), .d_req(d_req), .d_we(d_we), .d_io_instr(d_io),
        .d_ptr_sel(dsel), .d_addr(da), .d_valid(d_valid), .d_we_out(d_we_out),
        .d_region(d_region), .d_eff_addr(eff), .d_offset(off), .fetch_req(fetch_req),
        .fetch_pc(fpc), .fetch_valid(fetch_valid), .fetch_fault(fetch_fault),
        .fetch_word(fw), .pm_rd_req(pm_req), .pm_rd_pc(fpc), .pm_rd_valid(pm_valid),
        .pm_rd_denied(pm_denied), .pm_rd_word(pm_word), .spm_req(spm_req), .spm_pc(spm_pc),
        .spm_addr(spm_addr), .spm_data(spm_data), .spm_busy(spm_busy), .spm_done(spm_done),
        .spm_refused(spm_refused), .lock_app(la), .lock_tbl(lt), .lock_boot(lb),
        .ext_req(ext_req), .ext_we(ext_we), .ext_addr(ea), .ext_wdata(ewd),
        .ext_valid(ext_valid), .ext_denied(ext_denied), .ext_rdata(erd));
    mmp_core_model i_core (.clk(clk), .spm_done(spm_done), .spm_refused(spm_refused),
        .spm_req(spm_req), .spm_pc(spm_pc), .spm_addr(spm_addr), .spm_data(spm_data));
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    function automatic logic [1:0] exp_reg(input logic [15:0] a);
        if (a >= 16'h2000) return 2'h3;
        if (a >= 16'h1000) return 2'h2;
        return (a >= 16'h0040) ? 2'h1 : 2'h0;
    endfunction
    function automatic logic [15:0] exp_off(input logic [15:0] a);
        if (a >= 16'h2000) return a - 16'h2000;
        return (a >= 16'h1000) ? a - 16'h1000 : a;
    endfunction
    task automatic ext_op(input logic w, input logic [14:0] a, input logic [15:0] d);
        {ext_req, ext_we, ea, ewd} = {1'b1, w, a, d};
        // The request is left standing; the caller lowers it after the last call.
        tick();
        chk("ext_valid", {15'h0, ext_valid}, 16'h1);
        if (w) fm[a] = d;
    endtask
    task automatic fetch(input logic [14:0] a);
        {fetch_req, fpc} = {1'b1, a};
        tick();
        chk("fetch_fault", {15'h0, fetch_fault}, {15'h0, a > 15'h47ff});
        chk("fetch_word", fw, (a > 15'h47ff) ? 16'h0 : fm[a]);
    endtask
    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(3000 * 50);
        error_cnt++;
        conclude();
    end
    logic [14:0] spc [7] = '{15'h0100, 15'h4000, 15'h4000, 15'h4000, 15'h4000, 15'h4000, 15'h47ff};
    logic [14:0] sad [7] = '{15'h0010, 15'h0010, 15'h4001, 15'h3800, 15'h0010, 15'h47ff, 15'h3800};
    logic [5:0] slk [7] = '{6'h00, 6'h00, 6'h00, 6'h04, 6'h04, 6'h01, 6'h10};
    logic [15:0] dad [8] = '{16'h003f, 16'h0040, 16'h0fff, 16'h1000, 16'h1fff, 16'h2000, 0, 0};
    initial begin
        repeat (5) tick();
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            {rf_we, wa, wd} = {1'b1, 5'($random(seed)), 8'($random(seed))};
            tick();
            {rf_we, ra, rb} = {1'b0, wa, wa};
            tick();
            chk("rf_a", {8'h0, rda}, {8'h0, wd});
            chk("rf_b", {8'h0, rdb}, {8'h0, wd});
        end
        {rf_ptr_we, psel, pwd} = {1'b1, 2'h1, 16'($random(seed))};
        tick();
        rf_ptr_we = 1'b0;
        chk("ptr_x", px, pwd);
        for (int i = 0; i < 10; i++) begin
            {d_req, dsel, da} = {1'b1, 2'(i == 9), (i < 6) ? dad[i] : 16'($random(seed))};
            d_io = (i == 7);
            d_we = i[0];
            e = (i == 9) ? pwd : d_io ? {10'h0, da[5:0]} : da;
            tick();
            chk("d_valid", {14'h0, d_valid, d_we_out}, {14'h0, 1'b1, d_we});
            chk("d_region", {14'h0, d_region}, {14'h0, exp_reg(e)});
            chk("d_eff_addr", eff, e);
            chk("d_offset", off, exp_off(e));
        end
        d_req = 1'b0;
        foreach (sad[i]) ext_op(1'b1, sad[i], 16'($random(seed)));
        ext_req = 1'b0;
        foreach (sad[i]) fetch(sad[i]);
        fetch(15'h4800);
        fetch_req = 1'b0;
        foreach (spc[i]) begin
            {la, lt, lb} = slk[i];
            i_core.self_write(spc[i], sad[i], 16'($random(seed)), n, refd);
            if (!refd) fm[sad[i]] = spm_data ^ 16'hffff;
            chk("spm_refused", {15'h0, refd}, {15'h0, i inside {0, 3, 5}});
            chk("spm_cycles", 16'(n), refd ? 16'h2 : 16'h3);
            chk("spm_busy", {15'h0, spm_busy}, 16'h0);
            {la, lt, lb} = 6'h00;
            fetch(sad[i]);
            fetch_req = 1'b0;
        end
        {rf_ptr_we, psel, pwd, lt, fpc} = {1'b1, 2'h3, 16'h7000, 2'h2, 15'h0100};
        tick();
        {rf_ptr_we, pm_req} = 2'b01;
        chk("ptr_z", pz, 16'h7000);
        tick();
        chk("pm_rd_denied", {15'h0, pm_denied}, 16'h1);
        chk("pm_rd_word", pm_word, 16'h0);
        fpc = 15'h3800;
        tick();
        pm_req = 1'b0;
        chk("pm_rd_valid", {14'h0, pm_valid, pm_denied}, 16'h2);
        chk("pm_rd_word", pm_word, fm[15'h3800]);
        lb = 2'h2;
        ext_op(1'b0, 15'h4001, 16'h0);
        chk("ext_denied", {15'h0, ext_denied}, 16'h1);
        chk("ext_rdata", erd, 16'h0);
        lb = 2'h0;
        ext_op(1'b0, 15'h0010, 16'h0);
        chk("ext_rdata", erd, fm[15'h0010]);
        conclude();
    end
endmodule
`default_nettype wire
